/* rtl/flash_guard.sv */
// Serial flash mode control, write latch and block protection decode
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "flash_guard_params.svh"

module flash_guard #(
	parameter int REG_ADDR_W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Flash pins, two-way lines split into in, out, enable
	input wire logic sclk,
	input wire logic csN,
	input wire logic [3:0] ioIn,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe,
	// Array side
	input wire logic [7:0] rdByte,
	output logic byteTake,
	output logic [23:0] readAddr,
	output flash_guard_pkg::flash_req_s req,
	output logic refused,
	// Register port
	input wire logic [REG_ADDR_W-1:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [31:0] regRdata
);

	// ****************************************
	// Parameter check
	// ****************************************
	if (REG_ADDR_W < 4 || REG_ADDR_W > 16) begin : g_bad_width
		$error("REG_ADDR_W must lie between 4 and 16");
	end

	// ****************************************
	// Protection decode
	// ****************************************
	// True when [lo,hi] touches the protected region for these control bits
	function automatic logic region_hit(input logic [5:0] ctl, input logic [23:0] lo, input logic [23:0] hi);
		logic [2:0] low;
		logic [23:0] size;
		logic [23:0] rlo;
		logic [23:0] rhi;
		logic hit;
		low = ctl[2:0];
		size = 24'h000000;
		if (low == 3'h7) begin
			size = `FG_ARRAY_BYTES;
		end else if (low != 3'h0 && !ctl[4]) begin
			size = `FG_SIXTYFOURTH << (low - 3'h1);
		end else if (low != 3'h0) begin
			case (low)
				3'h1: size = 24'h001000;
				3'h2: size = 24'h002000;
				3'h3: size = 24'h004000;
				default: size = 24'h008000;
			endcase
		end
		// Bit 3 picks the bottom of the array, otherwise the top
		rlo = ctl[3] ? 24'h000000 : 24'(`FG_ARRAY_BYTES - size);
		rhi = ctl[3] ? 24'(size - 24'h000001) : `FG_ARRAY_LAST;
		hit = (size != 24'h000000) && (hi >= rlo) && (lo <= rhi);
		if (ctl[5]) begin
			// Complement: any part outside the plain region is protected
			hit = (size == 24'h000000) || (lo < rlo) || (hi > rhi);
		end
		return hit;
	endfunction

	// ****************************************
	// Pin synchronisers and edge detection
	// ****************************************
	logic sclkS1_q, sclkS2_q, sclkS3_q;
	logic csS1_q, csS2_q, csS3_q;
	logic [3:0] ioS1_q, ioS2_q;

	// Two stages before use; third stage only for edge finding
	always_ff @(posedge clk) begin
		if (srst) begin
			{sclkS1_q, sclkS2_q, sclkS3_q} <= 3'h0;
			{csS1_q, csS2_q, csS3_q} <= 3'h7;
			ioS1_q <= 4'h0;
			ioS2_q <= 4'h0;
		end else begin
			{sclkS1_q, sclkS2_q, sclkS3_q} <= {sclk, sclkS1_q, sclkS2_q};
			{csS1_q, csS2_q, csS3_q} <= {csN, csS1_q, csS2_q};
			ioS1_q <= ioIn;
			ioS2_q <= ioS1_q;
		end
	end

	// Edge based, so the idle level of the serial clock does not matter
	logic sclkRise, sclkFall, csRise, csHigh;
	assign sclkRise = sclkS2_q & ~sclkS3_q & ~csS2_q;
	assign sclkFall = ~sclkS2_q & sclkS3_q & ~csS2_q;
	assign csRise = csS2_q & ~csS3_q;
	assign csHigh = csS2_q;

	// ****************************************
	// State
	// ****************************************
	logic latch_q, fourLine_q, pdn_q, armed_q;
	logic [5:0] ctrl_q;
	logic [5:0] riseCnt_q;
	logic [7:0] opcode_q;
	logic opValid_q, addrValid_q;
	logic [23:0] shift_q, addr_q;
	logic [7:0] outSh_q;
	logic [2:0] outPos_q;
	logic [3:0] ioOut_q, ioOe_q;
	logic byteTake_q, refused_q;
	logic [23:0] readAddr_q;
	flash_guard_pkg::flash_req_s req_q, lastReq_q;
	logic [31:0] regRdata_q;

	// ****************************************
	// Phase decode of the current frame
	// ****************************************
	logic [5:0] opClks, addrClks, dummyClks, addrEnd, dataStart;
	logic [2:0] addrLanes, dataLanes, inLanes;
	logic isRead, hasAddr;
	assign isRead = opcode_q inside {`FG_OPC_READ, `FG_OPC_FAST_READ, `FG_OPC_DUAL_OUT, `FG_OPC_QUAD_OUT,
		`FG_OPC_DUAL_IO, `FG_OPC_QUAD_IO, `FG_OPC_WORD_IO};
	assign hasAddr = isRead || (opcode_q inside {`FG_OPC_PAGE_PGM, `FG_OPC_QUAD_PGM, `FG_OPC_SECTOR_ER,
		`FG_OPC_BLK32_ER, `FG_OPC_BLK64_ER, `FG_OPC_SECREG_ER, `FG_OPC_SECREG_PGM});
	// Four-line mode sends the opcode as two nibbles
	assign opClks = fourLine_q ? 6'd2 : 6'd8;
	assign addrLanes = fourLine_q ? 3'd4 :
		(opcode_q == `FG_OPC_DUAL_IO) ? 3'd2 :
		(opcode_q inside {`FG_OPC_QUAD_IO, `FG_OPC_WORD_IO}) ? 3'd4 : 3'd1;
	assign dataLanes = fourLine_q ? 3'd4 :
		(opcode_q inside {`FG_OPC_DUAL_OUT, `FG_OPC_DUAL_IO}) ? 3'd2 :
		(opcode_q inside {`FG_OPC_QUAD_OUT, `FG_OPC_QUAD_IO, `FG_OPC_WORD_IO, `FG_OPC_QUAD_PGM}) ? 3'd4 : 3'd1;
	assign addrClks = (addrLanes == 3'd4) ? 6'd6 : (addrLanes == 3'd2) ? 6'd12 : 6'd24;
	assign dummyClks = (opcode_q inside {`FG_OPC_FAST_READ, `FG_OPC_DUAL_OUT, `FG_OPC_QUAD_OUT}) ? `FG_DUMMY_FAST :
		(opcode_q == `FG_OPC_DUAL_IO) ? `FG_DUMMY_DUAL_IO :
		(opcode_q == `FG_OPC_QUAD_IO) ? `FG_DUMMY_QUAD_IO :
		(opcode_q == `FG_OPC_WORD_IO) ? `FG_DUMMY_WORD_IO : 6'd0;
	assign addrEnd = 6'(opClks + (hasAddr ? addrClks : 6'd0));
	assign dataStart = 6'(addrEnd + dummyClks);
	assign inLanes = (riseCnt_q < opClks) ? (fourLine_q ? 3'd4 : 3'd1) :
		(riseCnt_q < addrEnd) ? addrLanes : dataLanes;

	// Shift in one, two or four lanes per rising edge
	logic [23:0] shiftNext;
	assign shiftNext = (inLanes == 3'd4) ? {shift_q[19:0], ioS2_q} :
		(inLanes == 3'd2) ? {shift_q[21:0], ioS2_q[1:0]} : {shift_q[22:0], ioS2_q[0]};
	logic opDone, addrDone;
	assign opDone = sclkRise && (riseCnt_q == 6'(opClks - 6'd1));
	assign addrDone = sclkRise && opValid_q && hasAddr && (riseCnt_q == 6'(addrEnd - 6'd1));

	// Frame counters; everything restarts while chip select is high
	always_ff @(posedge clk) begin
		if (srst || csHigh) begin
			riseCnt_q <= 6'h00;
			opValid_q <= 1'b0;
			addrValid_q <= 1'b0;
			shift_q <= 24'h000000;
		end else if (sclkRise) begin
			riseCnt_q <= (riseCnt_q == 6'h3F) ? riseCnt_q : 6'(riseCnt_q + 6'd1);
			shift_q <= shiftNext;
			opValid_q <= opValid_q | opDone;
			addrValid_q <= addrValid_q | addrDone;
		end
	end

	// Opcode and address holding registers
	always_ff @(posedge clk) begin
		if (srst) begin
			opcode_q <= 8'h00;
			addr_q <= 24'h000000;
		end else begin
			if (opDone) begin
				opcode_q <= shiftNext[7:0];
			end
			if (addrDone) begin
				addr_q <= shiftNext;
			end
		end
	end

	// ****************************************
	// Command execution at the end of a frame
	// ****************************************
	logic execOk, swReset, isModify, needTarget, protHit, doReq;
	flash_guard_pkg::op_kind_e kind;
	logic [23:0] tgtStart, tgtEnd;
	// While powered down only wake and the reset pair get through
	assign execOk = csRise && opValid_q && (!pdn_q ||
		(opcode_q inside {`FG_OPC_WAKE, `FG_OPC_RST_ARM, `FG_OPC_RST_GO}));
	assign swReset = execOk && (opcode_q == `FG_OPC_RST_GO) && armed_q;
	assign kind = (opcode_q == `FG_OPC_STATUS_WR) ? flash_guard_pkg::OP_STATUS_WRITE :
		(opcode_q inside {`FG_OPC_PAGE_PGM, `FG_OPC_QUAD_PGM}) ? flash_guard_pkg::OP_PAGE_PROGRAM :
		(opcode_q == `FG_OPC_SECTOR_ER) ? flash_guard_pkg::OP_SECTOR_ERASE :
		(opcode_q == `FG_OPC_BLK32_ER) ? flash_guard_pkg::OP_BLOCK32_ERASE :
		(opcode_q == `FG_OPC_BLK64_ER) ? flash_guard_pkg::OP_BLOCK64_ERASE :
		(opcode_q inside {`FG_OPC_CHIP_ER_A, `FG_OPC_CHIP_ER_B}) ? flash_guard_pkg::OP_CHIP_ERASE :
		(opcode_q == `FG_OPC_SECREG_ER) ? flash_guard_pkg::OP_SECREG_ERASE :
		(opcode_q == `FG_OPC_SECREG_PGM) ? flash_guard_pkg::OP_SECREG_PROGRAM : flash_guard_pkg::OP_NONE;
	assign isModify = (kind != flash_guard_pkg::OP_NONE);
	assign needTarget = kind inside {flash_guard_pkg::OP_PAGE_PROGRAM, flash_guard_pkg::OP_SECTOR_ERASE,
		flash_guard_pkg::OP_BLOCK32_ERASE, flash_guard_pkg::OP_BLOCK64_ERASE};
	// Align the target to its page, sector or block; sector n sits at n*4096
	assign tgtStart = (kind == flash_guard_pkg::OP_PAGE_PROGRAM) ? (addr_q & `FG_PAGE_MASK) :
		(kind == flash_guard_pkg::OP_SECTOR_ERASE) ? (addr_q & `FG_SECTOR_MASK) :
		(kind == flash_guard_pkg::OP_BLOCK32_ERASE) ? (addr_q & `FG_BLK32_MASK) : (addr_q & `FG_BLK64_MASK);
	assign tgtEnd = (kind == flash_guard_pkg::OP_PAGE_PROGRAM) ? (tgtStart | `FG_PAGE_SPAN) :
		(kind == flash_guard_pkg::OP_SECTOR_ERASE) ? (tgtStart | `FG_SECTOR_SPAN) :
		(kind == flash_guard_pkg::OP_BLOCK32_ERASE) ? (tgtStart | `FG_BLK32_SPAN) : (tgtStart | `FG_BLK64_SPAN);
	// Chip erase runs only when no byte of the array is protected
	assign protHit = needTarget ? region_hit(ctrl_q, tgtStart, tgtEnd) :
		(kind == flash_guard_pkg::OP_CHIP_ERASE) ? region_hit(ctrl_q, 24'h000000, `FG_ARRAY_LAST) : 1'b0;
	assign doReq = execOk && isModify && latch_q && (!needTarget || addrValid_q) && !protHit;

	// Next values of the mode state
	logic latch_d, fourLine_d, pdn_d, armed_d;
	assign latch_d = swReset ? 1'b0 :
		(execOk && opcode_q == `FG_OPC_SET_LATCH) ? 1'b1 :
		(execOk && (opcode_q == `FG_OPC_CLR_LATCH || isModify)) ? 1'b0 : latch_q;
	// A single flag keeps the two command modes exclusive
	assign fourLine_d = swReset ? 1'b0 :
		(execOk && opcode_q == `FG_OPC_FOUR_ON) ? 1'b1 :
		(execOk && opcode_q == `FG_OPC_FOUR_OFF) ? 1'b0 : fourLine_q;
	assign pdn_d = swReset ? 1'b0 :
		(execOk && opcode_q == `FG_OPC_SLEEP) ? 1'b1 :
		(execOk && opcode_q == `FG_OPC_WAKE) ? 1'b0 : pdn_q;
	// Any other accepted command breaks the reset pair
	assign armed_d = execOk ? (opcode_q == `FG_OPC_RST_ARM) : armed_q;

	// Mode state and request pulses
	always_ff @(posedge clk) begin
		if (srst) begin
			latch_q <= 1'b0;
			fourLine_q <= 1'b0;
			pdn_q <= 1'b0;
			armed_q <= 1'b0;
			req_q <= '0;
			refused_q <= 1'b0;
			lastReq_q <= '0;
		end else begin
			latch_q <= latch_d;
			fourLine_q <= fourLine_d;
			pdn_q <= pdn_d;
			armed_q <= armed_d;
			req_q <= doReq ? {1'b1, kind, addr_q} : '0;
			refused_q <= execOk && isModify && !doReq;
			if (doReq) begin
				lastReq_q <= {1'b1, kind, addr_q};
			end
		end
	end

	// ****************************************
	// Read data path
	// ****************************************
	// Reads never consult protection: protected data stays readable
	logic readActive, loadByte;
	logic [7:0] outSrc;
	assign readActive = opValid_q && isRead && !pdn_q && (riseCnt_q >= dataStart);
	assign loadByte = sclkFall && readActive && (outPos_q == 3'h0);
	assign outSrc = (outPos_q == 3'h0) ? rdByte : outSh_q;

	// Output lanes change on falling edges, and are cleared and released while chip select is high
	always_ff @(posedge clk) begin
		if (srst || csHigh) begin
			outSh_q <= 8'h00;
			outPos_q <= 3'h0;
			ioOut_q <= 4'h0;
			ioOe_q <= 4'h0;
		end else if (sclkFall && readActive) begin
			outSh_q <= outSrc << dataLanes;
			outPos_q <= 3'(outPos_q + dataLanes);
			ioOut_q <= (dataLanes == 3'd4) ? outSrc[7:4] :
				(dataLanes == 3'd2) ? {2'b00, outSrc[7:6]} : {2'b00, outSrc[7], 1'b0};
			ioOe_q <= (dataLanes == 3'd4) ? 4'hF : (dataLanes == 3'd2) ? 4'h3 : 4'h2;
		end
	end

	// Byte address toward the array advances after each byte taken
	always_ff @(posedge clk) begin
		if (srst) begin
			readAddr_q <= 24'h000000;
			byteTake_q <= 1'b0;
		end else begin
			byteTake_q <= loadByte;
			if (addrDone) begin
				readAddr_q <= shiftNext;
			end else if (loadByte) begin
				readAddr_q <= 24'(readAddr_q + 24'h000001);
			end
		end
	end

	// ****************************************
	// Register port
	// ****************************************
	logic hitCtrl, hitStatus, hitLast;
	logic [31:0] rdMux;
	assign hitCtrl = (regAddr == REG_ADDR_W'(`FG_OFF_CTRL));
	assign hitStatus = (regAddr == REG_ADDR_W'(`FG_OFF_STATUS));
	assign hitLast = (regAddr == REG_ADDR_W'(`FG_OFF_LASTREQ));
	assign rdMux = hitCtrl ? {26'h0, ctrl_q} :
		hitStatus ? {29'h0, pdn_q, fourLine_q, latch_q} :
		hitLast ? {3'h0, lastReq_q} : 32'h00000000;

	// Control bits steer the protection decode; data valid one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl_q <= `FG_CTRL_RST;
			regRdata_q <= 32'h00000000;
		end else begin
			if (regWr && hitCtrl) begin
				ctrl_q <= regWdata[`FG_CTRL_INV_BIT:`FG_CTRL_PROT_LSB];
			end
			regRdata_q <= regRd ? rdMux : 32'h00000000;
		end
	end

	assign ioOut = ioOut_q;
	assign ioOe = ioOe_q;
	assign byteTake = byteTake_q;
	assign readAddr = readAddr_q;
	assign req = req_q;
	assign refused = refused_q;
	assign regRdata = regRdata_q;

	// ****************************************
	// Checks
	// ****************************************
	chk_latch_set: assert property (@(posedge clk) disable iff (srst)
		execOk && opcode_q == `FG_OPC_SET_LATCH && !swReset |=> latch_q)
		else $error("write latch not set by set command");
	chk_latch_clear: assert property (@(posedge clk) disable iff (srst)
		execOk && (isModify || opcode_q == `FG_OPC_CLR_LATCH) |=> !latch_q)
		else $error("write latch not cleared");
	chk_req_needs_latch: assert property (@(posedge clk) disable iff (srst)
		req_q.valid |-> $past(latch_q) && !latch_q)
		else $error("request issued without write latch");
	chk_four_enter: assert property (@(posedge clk) disable iff (srst)
		execOk && opcode_q == `FG_OPC_FOUR_ON |=> fourLine_q)
		else $error("four-line mode not entered");
	chk_four_leave: assert property (@(posedge clk) disable iff (srst)
		execOk && opcode_q == `FG_OPC_FOUR_OFF |=> !fourLine_q)
		else $error("four-line mode not left");
	chk_reset_mode: assert property (@(posedge clk) disable iff (srst)
		swReset |=> !fourLine_q && !latch_q && !pdn_q)
		else $error("reset pair did not restore serial mode");
	chk_down_ignore: assert property (@(posedge clk) disable iff (srst)
		pdn_q && csRise && opValid_q && opcode_q == `FG_OPC_SET_LATCH |=> $stable(latch_q) && pdn_q)
		else $error("command acted on while powered down");
	chk_protect_refuse: assert property (@(posedge clk) disable iff (srst)
		execOk && needTarget && latch_q && protHit |=> refused_q && !req_q.valid)
		else $error("protected target not refused");
	chk_full_protect: assert property (@(posedge clk) disable iff (srst)
		ctrl_q[2:0] == 3'h7 && !ctrl_q[5] && needTarget |-> protHit)
		else $error("whole-array code left a target open");
	chk_idle_release: assert property (@(posedge clk) disable iff (srst)
		csHigh |=> ioOe == 4'h0)
		else $error("data lines driven with chip deselected");

endmodule

/* rtl/flash_guard_params.svh */
// Offsets, field positions, reset values, geometry and opcodes of the flash guard
`ifndef FLASH_GUARD_PARAMS_SVH
`define FLASH_GUARD_PARAMS_SVH

// ****************************************
// Register offsets and fields
// ****************************************
`define FG_OFF_CTRL 8'h00
`define FG_OFF_STATUS 8'h04
`define FG_OFF_LASTREQ 8'h08
`define FG_CTRL_PROT_LSB 0
`define FG_CTRL_INV_BIT 5
`define FG_CTRL_RST 6'h00
`define FG_STAT_LATCH_BIT 0
`define FG_STAT_FOUR_BIT 1
`define FG_STAT_DOWN_BIT 2

// ****************************************
// Array geometry
// ****************************************
`define FG_ARRAY_BYTES 24'h800000
`define FG_ARRAY_LAST 24'h7FFFFF
`define FG_PAGE_MASK 24'hFFFF00
`define FG_SECTOR_MASK 24'hFFF000
`define FG_BLK32_MASK 24'hFF8000
`define FG_BLK64_MASK 24'hFF0000
`define FG_PAGE_SPAN 24'h0000FF
`define FG_SECTOR_SPAN 24'h000FFF
`define FG_BLK32_SPAN 24'h007FFF
`define FG_BLK64_SPAN 24'h00FFFF
`define FG_SIXTYFOURTH 24'h020000

// ****************************************
// Opcodes and dummy clock counts
// ****************************************
`define FG_OPC_SET_LATCH 8'h06
`define FG_OPC_CLR_LATCH 8'h04
`define FG_OPC_STATUS_WR 8'h01
`define FG_OPC_PAGE_PGM 8'h02
`define FG_OPC_QUAD_PGM 8'h32
`define FG_OPC_SECTOR_ER 8'h20
`define FG_OPC_BLK32_ER 8'h52
`define FG_OPC_BLK64_ER 8'hD8
`define FG_OPC_CHIP_ER_A 8'h60
`define FG_OPC_CHIP_ER_B 8'hC7
`define FG_OPC_SECREG_ER 8'h44
`define FG_OPC_SECREG_PGM 8'h42
`define FG_OPC_READ 8'h03
`define FG_OPC_FAST_READ 8'h0B
`define FG_OPC_DUAL_OUT 8'h3B
`define FG_OPC_QUAD_OUT 8'h6B
`define FG_OPC_DUAL_IO 8'hBB
`define FG_OPC_QUAD_IO 8'hEB
`define FG_OPC_WORD_IO 8'hE7
`define FG_OPC_FOUR_ON 8'h38
`define FG_OPC_FOUR_OFF 8'hFF
`define FG_OPC_RST_ARM 8'h66
`define FG_OPC_RST_GO 8'h99
`define FG_OPC_SLEEP 8'hB9
`define FG_OPC_WAKE 8'hAB
`define FG_DUMMY_FAST 6'd8
`define FG_DUMMY_DUAL_IO 6'd4
`define FG_DUMMY_QUAD_IO 6'd6
`define FG_DUMMY_WORD_IO 6'd4

`endif

/* rtl/flash_guard_pkg.sv */
// Types shared by the flash guard and its bench
package flash_guard_pkg;

	// Kind of array-modifying request handed to the array side
	typedef enum logic [3:0] {
		OP_NONE,
		OP_STATUS_WRITE,
		OP_PAGE_PROGRAM,
		OP_SECTOR_ERASE,
		OP_BLOCK32_ERASE,
		OP_BLOCK64_ERASE,
		OP_CHIP_ERASE,
		OP_SECREG_ERASE,
		OP_SECREG_PROGRAM
	} op_kind_e;

	// Accepted request, valid for one cycle
	typedef struct packed {
		logic valid;
		op_kind_e kind;
		logic [23:0] addr;
	} flash_req_s;

endpackage

/* test/spi_host_model.sv */
// Host-side serial flash controller model: drives serial clock, chip select and data lines
`timescale 1ns/1ps
module spi_host_model (
	// Clock
	input wire logic clk,
	// Flash pins
	output logic sclk,
	output logic csN,
	output logic [3:0] ioIn
);
	// Deselected and idle at time zero
	initial begin
		sclk = 1'b0;
		csN = 1'b1;
		ioIn = 4'h0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Shifts n bits MSB first over the given lanes; unused lanes carry noise the device must ignore
	task automatic shift(input logic [31:0] v, input int n, input int lanes);
		logic [31:0] s;
		logic [3:0] d;
		s = v << (32 - n);
		for (int i = 0; i < n; i += lanes) begin
			d = 4'($urandom);
			for (int b = 0; b < lanes; b++) d[b] = s[32 - lanes + b];
			s = s << lanes;
			sclk <= 1'b0;
			ioIn <= d;
			tick(4);
			sclk <= 1'b1;
			tick(4);
		end
	endtask

	// One frame; idle clock level picks mode 0 or 3, and released data lines flip so stale bits never pass
	task automatic frame(input logic m3, input logic [7:0] op, input int opLanes, input logic [31:0] arg,
		input int argBits, input int argLanes);
		sclk <= m3;
		tick(4);
		csN <= 1'b0;
		tick(4);
		shift({24'h000000, op}, 8, opLanes);
		if (argBits > 0) shift(arg, argBits, argLanes);
		sclk <= m3;
		tick(4);
		csN <= 1'b1;
		ioIn <= ~ioIn;
		tick(8);
	endtask
endmodule

/* test/tb.sv */
// Self-checking bench for the flash guard: modes, write latch and protection
`timescale 1ns/1ps
module tb;
	// ****************
	// Signals and notes
	// ****************
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic sclk;
	logic csN;
	logic [3:0] ioIn;
	logic [3:0] ioOut;
	logic [3:0] ioOe;
	logic [7:0] rdByte = 8'h00;
	logic byteTake;
	logic [23:0] readAddr;
	flash_guard_pkg::flash_req_s req;
	logic refused;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h00000000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [31:0] regRdata;
	logic rdPend = 1'b0;
	logic quad = 1'b0;
	logic rdHold = 1'b0;
	logic [3:0] oePrev = 4'h0;
	logic [3:0] expOe = 4'h0;
	logic [23:0] rdAddrQ[$];
	int failures = 0;
	int total_checks = 0;
	logic [31:0] rdQ[$];
	flash_guard_pkg::flash_req_s reqQ[$];
	flash_guard_pkg::flash_req_s got;
	logic [31:0] gotRd;
	logic [23:0] a;
	int k;
	// Addressed modify commands, then the others
	logic [7:0] ops[5] = '{8'h02, 8'h32, 8'h20, 8'h52, 8'hD8};
	flash_guard_pkg::op_kind_e kinds[5] = '{flash_guard_pkg::OP_PAGE_PROGRAM, flash_guard_pkg::OP_PAGE_PROGRAM,
		flash_guard_pkg::OP_SECTOR_ERASE, flash_guard_pkg::OP_BLOCK32_ERASE, flash_guard_pkg::OP_BLOCK64_ERASE};
	logic [23:0] spans[5] = '{24'h0000FF, 24'h0000FF, 24'h000FFF, 24'h007FFF, 24'h00FFFF};
	logic [23:0] edges[10] = '{24'h000000, 24'h007000, 24'h008000, 24'h01F000, 24'h020000, 24'h3FF000,
		24'h7DF000, 24'h7E0000, 24'h7F7000, 24'h7FF000};
	logic [7:0] ops2[5] = '{8'h01, 8'h60, 8'hC7, 8'h44, 8'h42};
	int bits2[5] = '{8, 0, 0, 24, 24};
	flash_guard_pkg::op_kind_e kinds2[5] = '{flash_guard_pkg::OP_STATUS_WRITE, flash_guard_pkg::OP_CHIP_ERASE,
		flash_guard_pkg::OP_CHIP_ERASE, flash_guard_pkg::OP_SECREG_ERASE, flash_guard_pkg::OP_SECREG_PROGRAM};
	logic [5:0] ctl[4] = '{6'h00, 6'h27, 6'h07, 6'h20};

	// ****************
	// Design and host
	// ****************
	flash_guard #(.REG_ADDR_W(8)) u_flash_guard (.clk(clk), .srst(srst), .sclk(sclk), .csN(csN), .ioIn(ioIn),
		.ioOut(ioOut), .ioOe(ioOe), .rdByte(rdByte), .byteTake(byteTake), .readAddr(readAddr), .req(req),
		.refused(refused), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata));
	spi_host_model u_spi_host_model (.clk(clk), .sclk(sclk), .csN(csN), .ioIn(ioIn));

	// Clock, and a changing array byte, held still during reads so the lanes can be predicted
	always #5 clk = ~clk;
	always @(posedge clk) if (!rdHold) rdByte <= 8'($urandom);

	// ****************
	// Helpers
	// ****************
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("[ERR] %0t %s", $time, msg);
		end
	endtask

	task automatic final_report;
		if (failures == 0 && total_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	// Strobes are lowered a full cycle before the next one is raised
	task automatic regWrite(input logic [7:0] ad, input logic [31:0] d);
		regAddr <= ad;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		@(posedge clk);
	endtask

	task automatic regRead(input logic [7:0] ad, input logic [31:0] exp);
		rdQ.push_back(exp);
		regAddr <= ad;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic expectMod(input logic ok, input flash_guard_pkg::op_kind_e kd, input logic [23:0] ad);
		flash_guard_pkg::flash_req_s e;
		e.valid = ok;
		e.kind = kd;
		e.addr = ad;
		reqQ.push_back(e);
	endtask

	task automatic cmd(input logic [7:0] op, input logic [31:0] arg, input int n);
		u_spi_host_model.frame(1'($urandom), op, quad ? 4 : 1, arg, n, quad ? 4 : 1);
	endtask

	// Protected-or-not for a target span under a control value; invert flips to the other end
	function automatic logic isProt(input logic [5:0] c, input logic [23:0] ad, input logic [23:0] span);
		logic [23:0] lo;
		logic [23:0] hi;
		logic [23:0] t;
		logic [23:0] size;
		logic none;
		logic all;
		lo = 24'h000000;
		hi = 24'h7FFFFF;
		none = c[2:0] == 3'h0;
		all = c[2:0] == 3'h7;
		size = (c[4] ? 24'h001000 : 24'h020000) << ((c[4] && c[2:0] > 3'h3) ? 3'h3 : c[2:0] - 3'h1);
		if (!none && !all) begin
			if (c[3]) hi = size - 24'h000001;
			else lo = 24'h800000 - size;
			if (c[5]) begin
				t = lo;
				lo = (t == 24'h000000) ? hi + 24'h000001 : 24'h000000;
				hi = (t == 24'h000000) ? 24'h7FFFFF : t - 24'h000001;
			end
		end
		return !(c[5] ? all : none) && ad <= hi && (ad | span) >= lo;
	endfunction

	// Takes the oldest note whenever a read answer or a modify result appears
	always @(posedge clk) begin
		rdPend <= regRd && !srst;
		if (rdPend) begin
			gotRd = rdQ.pop_front();
			check(regRdata === gotRd, "register value");
		end
		// First driven cycle of a read shows the top bits of the byte on the right lanes
		oePrev <= ioOe;
		if (ioOe !== 4'h0 && oePrev === 4'h0) begin
			check(ioOe === expOe && ioOut === ((expOe == 4'hF) ? rdByte[7:4] : (expOe == 4'h3) ?
				{2'b00, rdByte[7:6]} : {2'b00, rdByte[7], 1'b0}), "read lanes");
		end
		if (byteTake === 1'b1) begin
			check(rdAddrQ.size() > 0 && readAddr === rdAddrQ.pop_front(), "read address");
		end
		if (req.valid === 1'b1 || refused === 1'b1) begin
			check(reqQ.size() > 0, "unexpected modify result");
			if (reqQ.size() > 0) begin
				got = reqQ.pop_front();
				check(req.valid === got.valid && refused === !got.valid && (!got.valid || req.kind === got.kind
					&& (got.kind > kinds2[0] && got.kind < kinds2[1] ? req.addr === got.addr : 1'b1)),
					"modify result");
			end
		end
	end

	// Hang guard
	initial begin
		repeat (99000) @(posedge clk);
		check(1'b0, "timeout");
		final_report();
	end

	// ****************
	// Scenarios
	// ****************
	initial begin
		k = $urandom(32'h269C);
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		regRead(8'h04, 32'h00000000);
		regRead(8'h00, 32'h00000000);
		regRead(8'h0C, 32'h00000000);
		regWrite(8'h04, 32'hFFFFFFFF);
		regRead(8'h04, 32'h00000000);
		// Modify with the latch clear, also after set then clear
		expectMod(1'b0, kinds[2], 24'h100000);
		cmd(8'h20, 32'h00100000, 24);
		cmd(8'h06, 32'h0, 0);
		cmd(8'h04, 32'h0, 0);
		regRead(8'h04, 32'h00000000);
		expectMod(1'b0, kinds[0], 24'h000000);
		cmd(8'h02, 32'h0, 24);
		// Every control value against boundary and random targets
		for (int c = 0; c < 64; c++) begin
			regWrite(8'h00, 32'(c));
			regRead(8'h00, 32'(c));
			repeat (2) begin
				k = $urandom_range(0, 4);
				a = ($urandom_range(0, 1) ? edges[$urandom_range(0, 9)] : 24'($urandom)) & ~spans[k] & 24'h7FFFFF;
				cmd(8'h06, 32'h0, 0);
				regRead(8'h04, 32'h00000001);
				expectMod(!isProt(6'(c), a, spans[k]), kinds[k], a);
				cmd(ops[k], {8'h00, a}, 24);
				regRead(8'h04, 32'h00000000);
			end
		end
		// Unaddressed and security commands; chip erase only with nothing protected
		foreach (ctl[j]) for (int i = 0; i < 5; i++) begin
			regWrite(8'h00, {26'h0, ctl[j]});
			cmd(8'h06, 32'h0, 0);
			expectMod((i != 1 && i != 2) || !isProt(ctl[j], 24'h0, 24'h7FFFFF), kinds2[i], 24'h0);
			cmd(ops2[i], 32'($urandom), bits2[i]);
		end
		// Four-line command mode in and out
		regWrite(8'h00, 32'h00000000);
		cmd(8'h38, 32'h0, 0);
		quad = 1'b1;
		regRead(8'h04, 32'h00000002);
		cmd(8'h06, 32'h0, 0);
		regRead(8'h04, 32'h00000003);
		expectMod(1'b1, kinds[2], 24'h7FF000);
		cmd(8'h20, 32'h007FF000, 24);
		regRead(8'h08, {3'h0, 1'b1, flash_guard_pkg::OP_SECTOR_ERASE, 24'h7FF000});
		cmd(8'h99, 32'h0, 0);
		regRead(8'h04, 32'h00000002);
		cmd(8'hFF, 32'h0, 0);
		quad = 1'b0;
		regRead(8'h04, 32'h00000000);
		cmd(8'h38, 32'h0, 0);
		quad = 1'b1;
		cmd(8'h66, 32'h0, 0);
		cmd(8'h99, 32'h0, 0);
		quad = 1'b0;
		regRead(8'h04, 32'h00000000);
		// Reads in single, dual and four-line mode stay open under whole-array protection
		regWrite(8'h00, 32'h00000007);
		rdHold <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			a = 24'($urandom) & 24'h7FFFFF;
			if (i == 2) cmd(8'h38, 32'h0, 0);
			quad = (i == 2);
			rdAddrQ.push_back(24'(a + 24'h000001));
			expOe = (i == 0) ? 4'h2 : (i == 1) ? 4'h3 : 4'hF;
			u_spi_host_model.frame(i != 1, (i == 1) ? 8'hBB : 8'h03, quad ? 4 : 1, {a, 8'h00}, 32,
				(i == 1) ? 2 : (quad ? 4 : 1));
		end
		cmd(8'hFF, 32'h0, 0);
		quad = 1'b0;
		rdHold <= 1'b0;
		// Power-down filters commands until wake or the reset pair
		cmd(8'hB9, 32'h0, 0);
		regRead(8'h04, 32'h00000004);
		cmd(8'h06, 32'h0, 0);
		cmd(8'h20, 32'h0, 24);
		regRead(8'h04, 32'h00000004);
		cmd(8'hAB, 32'h0, 0);
		regRead(8'h04, 32'h00000000);
		cmd(8'hB9, 32'h0, 0);
		cmd(8'h66, 32'h0, 0);
		cmd(8'h99, 32'h0, 0);
		regRead(8'h04, 32'h00000000);
		// Reset in mid-run clears latch and mode
		cmd(8'h06, 32'h0, 0);
		cmd(8'h38, 32'h0, 0);
		srst <= 1'b1;
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		regRead(8'h04, 32'h00000000);
		for (int i = 0; i < 50 && (reqQ.size() > 0 || rdQ.size() > 0 || rdAddrQ.size() > 0); i++) @(posedge clk);
		check(reqQ.size() == 0 && rdQ.size() == 0 && rdAddrQ.size() == 0, "result missing");
		final_report();
	end
endmodule
